// ---- src/wdslp_cfg.svh ----
`ifndef WDSLP_CFG_SVH
`define WDSLP_CFG_SVH
// register map, byte-wide data on the plain port
`define WDSLP_ADDR_W          14
`define WDSLP_OFF_OPTION      14'h0081
`define WDSLP_OFF_OPTION_ALT  14'h0181
`define WDSLP_OFF_CONFIG      14'h2007
`define WDSLP_OFF_STATUS      14'h0003
`define WDSLP_OFF_INTFLAG     14'h0010
`define WDSLP_OFF_INTEN       14'h0011
`define WDSLP_OFF_PIN_OUT     14'h0012
`define WDSLP_OFF_PIN_OE      14'h0013
`define WDSLP_OPTION_RST      8'hff
`define WDSLP_CONFIG_RST      8'hff
// field positions
`define WDSLP_OPT_PSA_BIT     3
`define WDSLP_CFG_WDTEN_BIT   2
`define WDSLP_CFG_EXTCLK_BIT  0
`define WDSLP_ST_PD_BIT       3
`define WDSLP_ST_TO_BIT       4
// timing
`define WDSLP_BASE_PERIOD_US  18000
`define WDSLP_WD_OSC_KHZ      31
`define WDSLP_OST_CYCLES      1024
`define WDSLP_WD_OSC_DIV      6452
`define WDSLP_BASE_TICKS      558
`define WDSLP_NUM_WAKE_SRC    8
`endif

// ---- src/wdslp_pkg.sv ----
`default_nettype none
package wdslp_pkg;
  typedef enum logic [1:0] {WDSLP_RUN, WDSLP_SLEEP, WDSLP_OST} wdslp_state_t;
  typedef logic [7:0] wdslp_byte_t;
endpackage
`default_nettype wire

// ---- src/wdslp_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdslp_cfg.svh"
module wdslp_prescaler #(
  parameter int DIV_W = 7
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_clear,
  input  wire logic       i_tick,
  input  wire logic       i_bypass,
  input  wire logic [2:0] i_ratio_sel,
  output logic            o_tick
);
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] lim;
  assign lim = DIV_W'((8'h01 << i_ratio_sel) - 8'h01);
  assign o_tick = i_tick & (i_bypass | (cnt_r == lim));
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || i_clear || i_bypass) begin
      cnt_r <= '0;
    end else if (i_tick) begin
      cnt_r <= (cnt_r == lim) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule // wdslp_prescaler
`default_nettype wire

// ---- src/wdslp_wdt_osc.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdslp_cfg.svh"
// stands in for the dedicated rc oscillator; never gated by sleep
module wdslp_wdt_osc #(
  parameter int DIV = `WDSLP_WD_OSC_DIV
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  output logic      o_tick
);
  logic [15:0] cnt_r;
  assign o_tick = (cnt_r == 16'(DIV - 1));
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || o_tick) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule // wdslp_wdt_osc
`default_nettype wire

// ---- src/wdslp_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdslp_cfg.svh"
module wdslp_ctrl
#(
  parameter int WD_OSC_DIV = `WDSLP_WD_OSC_DIV,
  parameter int BASE_TICKS = `WDSLP_BASE_TICKS,
  parameter int OST_CYCLES = `WDSLP_OST_CYCLES,
  parameter int NSRC       = `WDSLP_NUM_WAKE_SRC
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rstn,
  input  wire logic                      i_por,
  input  wire logic [`WDSLP_ADDR_W-1:0]  i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [7:0]                o_rdata,
  input  wire logic                      i_clear_watchdog_instr,
  input  wire logic                      i_sleep_instr,
  input  wire logic [15:0]               i_pc,
  input  wire logic                      i_global_int_enable,
  input  wire logic [NSRC-1:0]           i_wake_src_pulse,
  input  wire logic                      i_master_clear_pin_n,
  input  wire logic [7:0]                i_pin_out_core,
  input  wire logic [7:0]                i_pin_oe_core,
  output logic      [7:0]                o_pin_out,
  output logic      [7:0]                o_pin_oe,
  output logic                           o_wdt_reset,
  output logic                           o_osc_run,
  output logic                           o_sleeping,
  output logic                           o_core_resume,
  output logic                           o_vector_after,
  output logic      [15:0]               o_prefetch_addr,
  output logic                           o_timeout_flag_n,
  output logic                           o_powerdown_flag_n
);
  import wdslp_pkg::*;

  wdslp_state_t state_r;
  wdslp_byte_t  option_r;
  wdslp_byte_t  config_r;
  wdslp_byte_t  int_flag_r;
  wdslp_byte_t  int_en_r;
  logic         to_n_r;
  logic         pd_n_r;
  logic [15:0]  wd_cnt_r;
  logic [10:0]  ost_cnt_r;
  logic [7:0]   pin_out_r;
  logic [7:0]   pin_oe_r;
  logic         osc_tick;
  logic         ps_tick;
  logic         wd_en;
  logic         wd_clr;
  logic         timeout;
  logic         pending;
  logic         sleep_go;
  logic         wake;
  logic         ext_clk;

  function automatic logic hit(input logic [`WDSLP_ADDR_W-1:0] a,
                               input logic [`WDSLP_ADDR_W-1:0] off);
    return a == off;
  endfunction

  assign wd_en    = config_r[`WDSLP_CFG_WDTEN_BIT];
  assign ext_clk  = config_r[`WDSLP_CFG_EXTCLK_BIT];
  assign pending  = |(int_flag_r & int_en_r);
  assign sleep_go = i_sleep_instr && state_r == WDSLP_RUN && !pending;
  assign wd_clr   = i_clear_watchdog_instr || sleep_go;

  wdslp_wdt_osc #(.DIV(WD_OSC_DIV)) u_osc (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .o_tick    (osc_tick)
  );

  // psa high routes the prescaler to the watchdog
  wdslp_prescaler #(.DIV_W(7)) u_ps (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_clear     (wd_clr),
    .i_tick      (osc_tick & wd_en),
    .i_bypass    (~option_r[`WDSLP_OPT_PSA_BIT]),
    .i_ratio_sel (option_r[2:0]),
    .o_tick      (ps_tick)
  );

  assign timeout = wd_en && ps_tick && (wd_cnt_r == 16'(BASE_TICKS - 1));

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || wd_clr || timeout || !wd_en) begin
      wd_cnt_r <= 16'h0000;
    end else if (ps_tick) begin
      wd_cnt_r <= wd_cnt_r + 16'h0001;
    end
  end

  // reset asserted as a pulse; master clear only forces the sleep state machine back to run
  assign o_wdt_reset = timeout && state_r == WDSLP_RUN;

  // interrupt flags: a set in the same cycle as a software clear wins
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      int_flag_r <= 8'h00;
    end else begin
      int_flag_r <= ((i_wr && hit(i_addr, `WDSLP_OFF_INTFLAG))
                     ? (int_flag_r & ~i_wdata) : int_flag_r)
                    | i_wake_src_pulse;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      int_en_r <= 8'h00;
      option_r <= `WDSLP_OPTION_RST;
    end else if (i_wr) begin
      if (hit(i_addr, `WDSLP_OFF_INTEN)) begin
        int_en_r <= i_wdata;
      end
      if (hit(i_addr, `WDSLP_OFF_OPTION) ||
          hit(i_addr, `WDSLP_OFF_OPTION_ALT)) begin
        option_r <= i_wdata;
      end
    end
  end

  // non-volatile word: loaded at power-up, written by software only while i_rstn is low
  always_ff @(posedge i_ref_clk) begin
    if (i_por) begin
      config_r <= `WDSLP_CONFIG_RST;
    end else if (i_wr && hit(i_addr, `WDSLP_OFF_CONFIG) && !i_rstn) begin
      config_r <= i_wdata;
    end
  end

  // status flags survive ordinary reset; power-up sets both
  always_ff @(posedge i_ref_clk) begin
    if (i_por) begin
      pd_n_r <= 1'b1;
      to_n_r <= 1'b1;
    end else if (timeout) begin
      to_n_r <= 1'b0;
      if (sleep_go) begin
        pd_n_r <= 1'b0;
      end
    end else if (sleep_go) begin
      pd_n_r <= 1'b0;
      to_n_r <= 1'b1;
    end else if (i_clear_watchdog_instr) begin
      pd_n_r <= 1'b1;
      to_n_r <= 1'b1;
    end
  end

  // an enabled wake source latched before sleep makes sleep a no-op; one latched while asleep wakes at once
  assign wake = timeout || pending;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !i_master_clear_pin_n) begin
      state_r   <= WDSLP_RUN;
      ost_cnt_r <= 11'h000;
    end else begin
      unique case (state_r)
        WDSLP_RUN: begin
          if (sleep_go) begin
            state_r <= WDSLP_SLEEP;
          end
        end
        WDSLP_SLEEP: begin
          if (wake) begin
            state_r   <= ext_clk ? WDSLP_RUN : WDSLP_OST;
            ost_cnt_r <= 11'h000;
          end
        end
        WDSLP_OST: begin
          if (ost_cnt_r == 11'(OST_CYCLES - 1)) begin
            state_r <= WDSLP_RUN;
          end else begin
            ost_cnt_r <= ost_cnt_r + 11'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_prefetch_addr <= 16'h0000;
      o_vector_after  <= 1'b0;
    end else begin
      if (sleep_go) begin
        o_prefetch_addr <= i_pc + 16'h0001;
      end
      if (state_r != WDSLP_RUN) begin
        o_vector_after <= pending && i_global_int_enable;
      end
    end
  end

  // outputs frozen while asleep so pins keep their drive
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pin_out_r <= 8'h00;
      pin_oe_r  <= 8'h00;
    end else if (state_r == WDSLP_RUN && !sleep_go) begin
      pin_out_r <= i_pin_out_core;
      pin_oe_r  <= i_pin_oe_core;
    end
  end
  assign o_pin_out = pin_out_r;
  assign o_pin_oe  = pin_oe_r;

  assign o_sleeping         = state_r != WDSLP_RUN;
  assign o_osc_run          = state_r != WDSLP_SLEEP;
  assign o_core_resume      = state_r == WDSLP_RUN;
  assign o_timeout_flag_n   = to_n_r;
  assign o_powerdown_flag_n = pd_n_r;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (1'b1)
        hit(i_addr, `WDSLP_OFF_OPTION),
        hit(i_addr, `WDSLP_OFF_OPTION_ALT): o_rdata <= option_r;
        hit(i_addr, `WDSLP_OFF_CONFIG):  o_rdata <= config_r;
        hit(i_addr, `WDSLP_OFF_STATUS):
          o_rdata <= {3'h0, to_n_r, pd_n_r, 3'h0};
        hit(i_addr, `WDSLP_OFF_INTFLAG): o_rdata <= int_flag_r;
        hit(i_addr, `WDSLP_OFF_INTEN):   o_rdata <= int_en_r;
        default:                         o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  property p_run_timeout_resets;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (state_r == WDSLP_RUN && wd_en && ps_tick &&
       wd_cnt_r == 16'(BASE_TICKS - 1))
        |-> o_wdt_reset ##1 wd_cnt_r == 16'h0000;
  endproperty
  a_run_timeout_resets: assert property (p_run_timeout_resets)
    else $error("timeout in run gave no reset");

  property p_sleep_no_reset;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      state_r == WDSLP_SLEEP |-> !o_wdt_reset;
  endproperty
  a_sleep_no_reset: assert property (p_sleep_no_reset)
    else $error("reset raised while asleep");

  property p_disabled_quiet;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !wd_en |=> wd_cnt_r == 16'h0000;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("watchdog counted while disabled");

  property p_clear_zero;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      wd_clr |=> wd_cnt_r == 16'h0000;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("watchdog not cleared");

  property p_to_clears;
    @(posedge i_ref_clk) disable iff (!i_rstn || i_por)
      timeout |=> !o_timeout_flag_n;
  endproperty
  a_to_clears: assert property (p_to_clears)
    else $error("timeout flag not cleared");

  sequence s_sleep_taken;
    sleep_go && !timeout;
  endsequence
  property p_sleep_flags;
    @(posedge i_ref_clk) disable iff (!i_rstn || i_por)
      s_sleep_taken |=> !o_powerdown_flag_n && o_timeout_flag_n;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep flags wrong");

  property p_pins_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      state_r == WDSLP_SLEEP ##1 state_r == WDSLP_SLEEP
        |-> $stable(o_pin_out) && $stable(o_pin_oe);
  endproperty
  a_pins_hold: assert property (p_pins_hold)
    else $error("pins changed in sleep");

  property p_pending_noop;
    @(posedge i_ref_clk) disable iff (!i_rstn || i_por)
      (i_sleep_instr && pending && state_r == WDSLP_RUN)
        |=> state_r == WDSLP_RUN && $stable(o_powerdown_flag_n);
  endproperty
  a_pending_noop: assert property (p_pending_noop)
    else $error("sleep not a no-op with pending interrupt");

  property p_ost_len;
    @(posedge i_ref_clk) disable iff (!i_rstn || !i_master_clear_pin_n)
      (state_r == WDSLP_SLEEP && wake && !ext_clk)
        |=> state_r == WDSLP_OST [*8];
  endproperty
  a_ost_len: assert property (p_ost_len)
    else $error("start-up delay cut short");

  property p_prefetch_next;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      sleep_go |=> o_prefetch_addr == $past(i_pc) + 16'h0001;
  endproperty
  a_prefetch_next: assert property (p_prefetch_next)
    else $error("prefetch address not pc plus one");

  // independent count of the start-up wait, checked at its exit
  logic [11:0] ost_seen_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || state_r != WDSLP_OST) begin
      ost_seen_r <= 12'h000;
    end else begin
      ost_seen_r <= ost_seen_r + 12'h001;
    end
  end
  sequence s_ost_exit;
    state_r == WDSLP_OST ##1 state_r == WDSLP_RUN;
  endsequence
  property p_ost_exact;
    @(posedge i_ref_clk) disable iff (!i_rstn || !i_master_clear_pin_n)
      s_ost_exit |-> $past(ost_seen_r) == 12'(OST_CYCLES - 1);
  endproperty
  a_ost_exact: assert property (p_ost_exact)
    else $error("start-up wait length wrong");
endmodule // wdslp_ctrl
`default_nettype wire

// ---- verif/wdslp_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// core side: issues instructions and wake events when the bench asks
module wdslp_core_model (
  input  wire logic        i_ref_clk,
  output logic             o_clear_watchdog_instr,
  output logic             o_sleep_instr,
  output logic      [15:0] o_pc,
  output logic             o_global_int_enable,
  output logic      [7:0]  o_wake_src_pulse,
  output logic      [7:0]  o_pin_out_core,
  output logic      [7:0]  o_pin_oe_core
);
  logic [7:0] pin_cnt_r = 8'h00;
  initial begin
    o_clear_watchdog_instr = 1'b0;
    o_sleep_instr          = 1'b0;
    o_pc                   = 16'h0000;
    o_global_int_enable    = 1'b0;
    o_wake_src_pulse       = 8'h00;
  end
  // pins keep moving in sleep too, so a leaky freeze cannot hide
  always @(posedge i_ref_clk) pin_cnt_r <= pin_cnt_r + 8'h01;
  assign o_pin_out_core = pin_cnt_r;
  assign o_pin_oe_core  = ~pin_cnt_r;
  task automatic clear_wd();
    @(posedge i_ref_clk);
    o_clear_watchdog_instr <= 1'b1;
    @(posedge i_ref_clk);
    o_clear_watchdog_instr <= 1'b0;
  endtask
  task automatic sleep_at(input logic [15:0] pc, input logic pre_clr,
                          input logic global_int_enable);
    if (pre_clr) clear_wd();
    @(posedge i_ref_clk);
    o_sleep_instr       <= 1'b1;
    o_pc                <= pc;
    o_global_int_enable <= global_int_enable;
    @(posedge i_ref_clk);
    o_sleep_instr <= 1'b0;
    // pc moves on; a design that samples late sees garbage
    o_pc          <= ~pc;
  endtask
  task automatic wake(input int src);
    @(posedge i_ref_clk);
    o_wake_src_pulse <= 8'h01 << src;
    @(posedge i_ref_clk);
    o_wake_src_pulse <= 8'h00;
  endtask
endmodule // wdslp_core_model
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdslp_cfg.svh"
module tb;
  import wdslp_pkg::*;
  localparam int OST = 16;
  localparam int W_RST = 0;
  localparam int W_RES = 1;
  localparam int W_SLP = 2;
  logic        i_ref_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_por = 1'b1;
  logic [13:0] i_addr = 14'h0000;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_master_clear_pin_n = 1'b1;
  logic        i_clear_watchdog_instr, i_sleep_instr, i_global_int_enable;
  logic [15:0] i_pc, o_prefetch_addr;
  logic [7:0]  i_wake_src_pulse, i_pin_out_core, i_pin_oe_core;
  logic [7:0]  o_rdata, o_pin_out, o_pin_oe;
  logic        o_wdt_reset, o_osc_run, o_sleeping, o_core_resume;
  logic        o_vector_after, o_timeout_flag_n, o_powerdown_flag_n;
  int          failures = 0;
  int          num_checks = 0;
  int          rst_seen = 0;
  int          c, r0, ex;
  logic [15:0] pins;
  logic [7:0]  opt_tab [3] = '{8'hf7, 8'hfa, 8'hff};
  int          exp_tab [3] = '{32, 128, 4096};

  always #2.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_wdt_reset === 1'b1) rst_seen <= rst_seen + 1;

  wdslp_core_model core (
    .i_ref_clk              (i_ref_clk),
    .o_clear_watchdog_instr (i_clear_watchdog_instr),
    .o_sleep_instr          (i_sleep_instr),
    .o_pc                   (i_pc),
    .o_global_int_enable    (i_global_int_enable),
    .o_wake_src_pulse       (i_wake_src_pulse),
    .o_pin_out_core         (i_pin_out_core),
    .o_pin_oe_core          (i_pin_oe_core)
  );
  wdslp_ctrl #(.WD_OSC_DIV(4), .BASE_TICKS(8), .OST_CYCLES(OST), .NSRC(8))
    uut (
    .i_ref_clk              (i_ref_clk),
    .i_rstn                 (i_rstn),
    .i_por                  (i_por),
    .i_addr                 (i_addr),
    .i_wdata                (i_wdata),
    .i_wr                   (i_wr),
    .i_rd                   (i_rd),
    .o_rdata                (o_rdata),
    .i_clear_watchdog_instr (i_clear_watchdog_instr),
    .i_sleep_instr          (i_sleep_instr),
    .i_pc                   (i_pc),
    .i_global_int_enable    (i_global_int_enable),
    .i_wake_src_pulse       (i_wake_src_pulse),
    .i_master_clear_pin_n   (i_master_clear_pin_n),
    .i_pin_out_core         (i_pin_out_core),
    .i_pin_oe_core          (i_pin_oe_core),
    .o_pin_out              (o_pin_out),
    .o_pin_oe               (o_pin_oe),
    .o_wdt_reset            (o_wdt_reset),
    .o_osc_run              (o_osc_run),
    .o_sleeping             (o_sleeping),
    .o_core_resume          (o_core_resume),
    .o_vector_after         (o_vector_after),
    .o_prefetch_addr        (o_prefetch_addr),
    .o_timeout_flag_n       (o_timeout_flag_n),
    .o_powerdown_flag_n     (o_powerdown_flag_n)
  );

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [13:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk({8'h00, o_rdata}, {8'h00, e});
  endtask
  // selects the watched output by number, no reference arguments needed
  function automatic logic pick(input int w);
    case (w)
      W_RST:   return o_wdt_reset;
      W_RES:   return o_core_resume;
      default: return o_sleeping;
    endcase
  endfunction
  // bounded wait; running out ends the run as a failure
  task automatic wait_lvl(input int w, input logic v, input int n);
    c = 0;
    while (pick(w) !== v && c < n) begin
      @(posedge i_ref_clk);
      #1 c++;
    end
    if (pick(w) !== v) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic reset_dut(input logic wcfg, input logic [7:0] cfg);
    @(posedge i_ref_clk);
    i_rstn <= 1'b0;
    i_por  <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    i_por <= 1'b0;
    if (wcfg) wr(`WDSLP_OFF_CONFIG, cfg);
    @(posedge i_ref_clk);
    i_rstn <= 1'b1;
  endtask

  initial begin
    reset_dut(1'b0, 8'h00);
    rd_chk(`WDSLP_OFF_STATUS, 8'h18);
    rd_chk(`WDSLP_OFF_OPTION, `WDSLP_OPTION_RST);
    rd_chk(`WDSLP_OFF_CONFIG, `WDSLP_CONFIG_RST);
    rd_chk(14'h0055, 8'h00);
    wr(`WDSLP_OFF_CONFIG, 8'h00);
    rd_chk(`WDSLP_OFF_CONFIG, 8'hff);
    wr(`WDSLP_OFF_OPTION_ALT, 8'h5a);
    rd_chk(`WDSLP_OFF_OPTION, 8'h5a);
    for (int k = 0; k < 3; k++) begin
      wr(`WDSLP_OFF_OPTION, opt_tab[k]);
      core.clear_wd();
      rd_chk(`WDSLP_OFF_STATUS, 8'h18);
      r0 = rst_seen;
      ex = exp_tab[k];
      wait_lvl(W_RST, 1'b1, 6000);
      chk_rng(c, ex - ex / 8 - 8, ex + ex / 8 + 8);
      rd_chk(`WDSLP_OFF_STATUS, 8'h08);
      core.clear_wd();
      rd_chk(`WDSLP_OFF_OPTION, opt_tab[k]);
    end
    // a time-out left the flag low; sleep must raise it again
    wr(`WDSLP_OFF_OPTION, 8'hf7);
    wait_lvl(W_RST, 1'b1, 200);
    core.sleep_at(16'h0123, 1'b0, 1'b0);
    #1 chk({11'h000, o_sleeping, o_osc_run, o_timeout_flag_n,
            o_powerdown_flag_n, 1'b0}, 16'h0014);
    chk(o_prefetch_addr, 16'h0124);
    pins = {o_pin_oe, o_pin_out};
    r0 = rst_seen;
    repeat (10) @(posedge i_ref_clk);
    #1 chk({o_pin_oe, o_pin_out}, pins);
    wait_lvl(W_RES, 1'b1, 200);
    chk(rst_seen[15:0], r0[15:0]);
    rd_chk(`WDSLP_OFF_STATUS, 8'h00);
    wr(`WDSLP_OFF_OPTION, 8'hff);
    for (int s = 0; s < 8; s++) begin
      wr(`WDSLP_OFF_INTFLAG, 8'hff);
      wr(`WDSLP_OFF_INTEN, 8'h01 << s);
      core.sleep_at(16'h0200, 1'b1, s[0]);
      core.wake((s + 1) % 8);
      repeat (8) @(posedge i_ref_clk);
      #1 chk({15'h0000, o_sleeping}, 16'h0001);
      core.wake(s);
      wait_lvl(W_RES, 1'b1, 20);
      chk({15'h0000, o_vector_after}, {15'h0000, s[0]});
    end
    wr(`WDSLP_OFF_INTFLAG, 8'hff);
    wr(`WDSLP_OFF_INTEN, 8'h01);
    core.wake(0);
    core.sleep_at(16'h0300, 1'b1, 1'b0);
    #1 chk({14'h0000, o_sleeping, o_powerdown_flag_n}, 16'h0001);
    wr(`WDSLP_OFF_INTFLAG, 8'hff);
    core.sleep_at(16'h0310, 1'b1, 1'b0);
    @(posedge i_ref_clk);
    i_master_clear_pin_n <= 1'b0;
    wait_lvl(W_SLP, 1'b0, 20);
    @(posedge i_ref_clk);
    i_master_clear_pin_n <= 1'b1;
    // crystal mode: start-up wait before the core resumes
    reset_dut(1'b1, 8'hfe);
    wr(`WDSLP_OFF_INTFLAG, 8'hff);
    wr(`WDSLP_OFF_INTEN, 8'h01);
    core.sleep_at(16'h0400, 1'b1, 1'b0);
    core.wake(0);
    wait_lvl(W_RES, 1'b1, OST + 40);
    chk_rng(c, OST - 2, OST + 4);
    reset_dut(1'b1, 8'hfa);
    wr(`WDSLP_OFF_OPTION, 8'hf7);
    r0 = rst_seen;
    repeat (300) @(posedge i_ref_clk);
    chk(rst_seen[15:0], r0[15:0]);
    stop_test();
  end
endmodule // tb
`default_nettype wire
